/* common/ilct_pkg.sv */
// shared constants, state type and opcode decode functions for the timing block
package ilct_pkg;

   // widths
   localparam int OP_W = 8;
   localparam int LEN_W = 2;
   localparam int CYC_W = 4;

   // instruction lengths in program bytes
   localparam logic [LEN_W-1:0] LEN_NONE = 2'h0;
   localparam logic [LEN_W-1:0] LEN_ONE = 2'h1;
   localparam logic [LEN_W-1:0] LEN_TWO = 2'h2;
   localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;

   // cycle counts
   localparam logic [CYC_W-1:0] CYC_ZERO = 4'h0;
   localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;
   localparam logic [CYC_W-1:0] CYC_IND = 4'h2;
   localparam logic [CYC_W-1:0] CYC_MEM = 4'h3;
   localparam logic [CYC_W-1:0] CYC_MUL = 4'h4;
   localparam logic [CYC_W-1:0] CYC_DIV = 4'h8;
   localparam logic [CYC_W-1:0] BR_EXTRA_DEF = 4'h1;

   // low opcode bits [3:1] that select an indirect register pointer
   localparam logic [2:0] IND_SEL = 3'h3;

   // execution states, gray along idle, exec, extend
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1,
      ST_EXTEND = 2'h3
   } ilct_state_e;

   // program bytes of an opcode, standard encoding
   function automatic logic [LEN_W-1:0] op_len(input logic [OP_W-1:0] op);
      logic [LEN_W-1:0] len;
      len = LEN_ONE;
      casez (op)
         // absolute jump and call
         8'h?1: len = LEN_TWO;
         // long jump/call, bit branches, direct-immediate forms, 16-bit pointer load
         8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63,
         8'h75, 8'h85, 8'h90, 8'hD5, 8'b1011_01??, 8'b1011_1???: len = LEN_THREE;
         // relative branches, direct, immediate, bit and stack forms
         8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h05, 8'h15, 8'h25, 8'h35,
         8'h45, 8'h55, 8'h65, 8'h95, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64,
         8'h74, 8'h94, 8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'hA0,
         8'hA2, 8'hB0, 8'hB2, 8'hC2, 8'hD2, 8'hC0, 8'hD0, 8'hC5, 8'hE5,
         8'hF5, 8'h86, 8'h87, 8'hA6, 8'hA7, 8'h76, 8'h77, 8'b0111_1???,
         8'b1000_1???, 8'b1010_1???, 8'b1101_1???: len = LEN_TWO;
         default: len = LEN_ONE;
      endcase
      return len;
   endfunction

   // cycles of an opcode, not-taken count for conditional branches
   function automatic logic [CYC_W-1:0] op_cycles(input logic [OP_W-1:0] op);
      logic [CYC_W-1:0] cyc;
      logic [LEN_W-1:0] len;
      len = op_len(op);
      cyc = {2'h0, len};
      casez (op)
         8'hA4: cyc = CYC_MUL;
         8'h84: cyc = CYC_DIV;
         // code reads and external data moves
         8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: cyc = CYC_MEM;
         default: begin
            // single-byte indirect pointer forms need a ram access cycle
            if ((op[3:1] == IND_SEL) && (len == LEN_ONE)) begin
               cyc = CYC_IND;
            end
         end
      endcase
      return cyc;
   endfunction

   // conditional branches that resolve late
   function automatic logic op_is_cond(input logic [OP_W-1:0] op);
      logic c;
      casez (op)
         8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'hD5,
         8'b1011_01??, 8'b1011_1???, 8'b1101_1???: c = 1'b1;
         default: c = 1'b0;
      endcase
      return c;
   endfunction

endpackage

/* src/ilct_opdec.sv */
// first-byte opcode decoder giving length, cycles and branch class
`timescale 1ns/100ps
module ilct_opdec
   import ilct_pkg::*;
(
   // opcode in
   input wire logic [OP_W-1:0] opcode,
   // decoded timing
   output logic [LEN_W-1:0] len,
   output logic [CYC_W-1:0] cycles,
   output logic is_cond
);

   // pure table lookup, one cycle count per clock, no machine cycles
   assign len = op_len(opcode);
   assign cycles = op_cycles(opcode);
   assign is_cond = op_is_cond(opcode);

endmodule

/* src/ilct_cnt.sv */
// loadable down counter for remaining execution cycles
`timescale 1ns/100ps
module ilct_cnt
   import ilct_pkg::*;
#(
   parameter int W = CYC_W
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic dec,
   // state
   output logic [W-1:0] count,
   output logic last
);

   // one is the final cycle still to run
   assign last = (count == W'(1));

   // load wins over decrement
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (clk_en) begin
         if (load) begin
            count <= load_val;
         end else if (dec && (count != '0)) begin
            count <= count - W'(1);
         end
      end
   end

endmodule

/* src/ilct_timer.sv */
// instruction length and cycle timer: paces execute per opcode
`timescale 1ns/100ps
// Functional notes
// - timing counted in single clocks only
// - cycles equal bytes unless listed otherwise; multiply takes 4 cycles, divide 8
// - branch not taken finishes BR_EXTRA cycles sooner, one cycle by default
// - register operand alu ops: 1 byte, 1 cycle
// - indirect ram operand: 1 byte, 2 cycles
// - direct operand alu ops: 2 bytes, 2 cycles
// - immediate operand alu ops: 2 bytes, 2 cycles
// - logic into direct byte: 2 bytes, 2 cycles
// - immediate into direct byte: 3 bytes, 3 cycles
// - accumulator rotates: 1 byte, 1 cycle
// - direct to direct move: 3 bytes, 3 cycles
// - store accumulator indirect: 1 byte, 2 cycles
// - immediate to indirect ram: 2 bytes, 2 cycles
// - data pointer load: 3 bytes, 3 cycles
// - code byte read: 1 byte, 3 cycles
// - external data read: 1 byte, 3 cycles
// - external data write: 1 byte, 3 cycles
// - push and pop: 2 bytes, 2 cycles
// - exchange direct with accumulator: 2 bytes, 2 cycles
// - nibble exchange indirect: 1 byte, 2 cycles
// - standard encoding, only timing differs
module ilct_timer
   import ilct_pkg::*;
#(
   parameter logic [CYC_W-1:0] BR_EXTRA = BR_EXTRA_DEF
)
(
   // clock, reset and enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // program byte stream from fetch
   input wire logic op_valid,
   input wire logic [OP_W-1:0] op_byte,
   output logic op_ready,
   // branch outcome from execute
   input wire logic cond_taken,
   // timing results to execute
   output logic dec_valid,
   output logic [LEN_W-1:0] instr_len,
   output logic [CYC_W-1:0] instr_cycles,
   output logic exec_busy,
   output logic instr_done
);

   // state and bookkeeping
   ilct_state_e state; // current phase
   ilct_state_e next_state; // phase after this edge
   logic [LEN_W-1:0] bytes_left; // operand bytes still to take
   logic [LEN_W-1:0] next_bytes_left; // bytes after this edge
   logic cond_q; // current opcode is a conditional branch
   logic next_done; // instruction finishes this cycle

   // decoder outputs
   wire logic [LEN_W-1:0] dec_len; // length of incoming opcode
   wire logic [CYC_W-1:0] dec_cyc; // cycles of incoming opcode
   wire logic dec_cond; // incoming opcode is a conditional branch

   // counter wiring
   wire logic [CYC_W-1:0] rem; // cycles still to run
   wire logic rem_last; // final counted cycle
   logic cnt_load; // reload the counter
   logic [CYC_W-1:0] cnt_val; // reload value
   logic cnt_dec; // count one cycle

   // decode of handshakes and phases
   wire logic idle_st = (state == ST_IDLE);
   wire logic exec_st = (state == ST_EXEC);
   wire logic ext_st = (state == ST_EXTEND);
   // opcode taken only while idle and enabled
   wire logic take_op = clk_en & op_valid & op_ready & idle_st;
   // a cycle counts only when its operand byte is present or no byte is owed
   wire logic advance = clk_en & ~idle_st & (~op_ready | op_valid);
   // operand byte consumed in this cycle
   wire logic take_byte = advance & (bytes_left != LEN_NONE);
   // single-cycle opcode closes at once
   wire logic one_cyc = (dec_cyc == CYC_ONE);
   // branch resolved taken on its last not-taken cycle
   wire logic br_taken = exec_st & rem_last & cond_q & cond_taken;

   // opcode lookup on the first byte
   ilct_opdec u_dec (
      .opcode(op_byte),
      .len(dec_len),
      .cycles(dec_cyc),
      .is_cond(dec_cond)
   );

   // remaining cycle counter
   ilct_cnt #(
      .W(CYC_W)
   ) u_cnt (
      .clk(clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .load(cnt_load),
      .load_val(cnt_val),
      .dec(cnt_dec),
      .count(rem),
      .last(rem_last)
   );

   // next state, counter control and completion
   always_comb begin
      next_state = state;
      next_done = 1'b0;
      cnt_load = 1'b0;
      cnt_val = CYC_ZERO;
      cnt_dec = 1'b0;
      case (state)
         ST_IDLE: begin
            if (take_op) begin
               if (one_cyc) begin
                  // one byte, one clock, stay ready
                  next_done = 1'b1;
               end else begin
                  // opcode cycle already spent
                  next_state = ST_EXEC;
                  cnt_load = 1'b1;
                  cnt_val = dec_cyc - CYC_ONE;
               end
            end
         end
         ST_EXEC: begin
            if (advance) begin
               if (rem_last && br_taken) begin
                  // taken branch runs the extra cycles
                  next_state = ST_EXTEND;
                  cnt_load = 1'b1;
                  cnt_val = BR_EXTRA;
               end else if (rem_last) begin
                  // not taken or ordinary end
                  next_state = ST_IDLE;
                  next_done = 1'b1;
               end else begin
                  cnt_dec = 1'b1;
               end
            end
         end
         ST_EXTEND: begin
            // extension cycles count with no byte owed
            if (advance && rem_last) begin
               // last extension cycle hands back to idle
               next_state = ST_IDLE;
               next_done = 1'b1;
            end else begin
               cnt_dec = advance;
            end
         end
         default: begin
            // unreachable code recovers to idle
            next_state = ST_IDLE;
         end
      endcase
   end

   // operand byte bookkeeping
   always_comb begin
      next_bytes_left = bytes_left;
      if (take_op) begin
         next_bytes_left = dec_len - LEN_ONE;
      end else if (take_byte) begin
         next_bytes_left = bytes_left - LEN_ONE;
      end
   end

   // phase and byte registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         bytes_left <= LEN_NONE;
      end else if (clk_en) begin
         state <= next_state;
         bytes_left <= next_bytes_left;
      end
   end

   // branch class held for the instruction
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cond_q <= 1'b0;
      end else if (take_op) begin
         cond_q <= dec_cond;
      end
   end

   // decode results published the edge after the opcode
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         instr_len <= LEN_NONE;
         instr_cycles <= CYC_ZERO;
      end else if (take_op) begin
         instr_len <= dec_len;
         instr_cycles <= dec_cyc;
      end
   end

   // handshake and status outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         op_ready <= 1'b1;
         dec_valid <= 1'b0;
         exec_busy <= 1'b0;
         instr_done <= 1'b0;
      end else if (clk_en) begin
         // ready for an opcode when idle, else for an operand byte
         op_ready <= (next_state == ST_IDLE) || (next_bytes_left != LEN_NONE);
         dec_valid <= take_op;
         exec_busy <= (next_state != ST_IDLE);
         instr_done <= next_done;
      end
   end

   // helper: counted cycles and branch extension of this instruction
   logic [CYC_W-1:0] run_cnt; // counted cycles so far
   logic ext_seen; // branch was taken
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         run_cnt <= CYC_ZERO;
         ext_seen <= 1'b0;
      end else if (take_op) begin
         run_cnt <= CYC_ONE;
         ext_seen <= 1'b0;
      end else if (advance) begin
         run_cnt <= run_cnt + CYC_ONE;
         ext_seen <= ext_seen | br_taken;
      end
   end

   // opcode taken in each timing class; the assertions below hold the enable for the following cycles
   sequence s_take_one;
      take_op && one_cyc;
   endsequence
   sequence s_take_two;
      take_op && (dec_len == LEN_TWO) && !dec_cond && (dec_cyc == CYC_IND);
   endsequence
   sequence s_take_ind;
      take_op && (dec_len == LEN_ONE) && (dec_cyc == CYC_IND);
   endsequence
   sequence s_take_three;
      take_op && (dec_len == LEN_THREE) && !dec_cond;
   endsequence
   sequence s_take_mem;
      take_op && (dec_len == LEN_ONE) && (dec_cyc == CYC_MEM);
   endsequence
   // multiply and divide run their longer fixed counts
   sequence s_take_mul;
      take_op && (dec_len == LEN_ONE) && (dec_cyc == CYC_MUL);
   endsequence
   sequence s_take_div;
      take_op && (dec_len == LEN_ONE) && (dec_cyc == CYC_DIV);
   endsequence

   single_cycle_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_one |=> instr_done && !exec_busy && op_ready)
      else $error("single cycle opcode did not finish in one clock");

   dec_result_a: assert property (
      @(posedge clk) disable iff (!resetn)
      take_op |=> dec_valid && (instr_len == op_len($past(op_byte)))
         && (instr_cycles == op_cycles($past(op_byte))))
      else $error("decode result not published after opcode");

   dur_count_a: assert property (
      @(posedge clk) disable iff (!resetn)
      (clk_en && next_done && !idle_st) |->
         (run_cnt + CYC_ONE == instr_cycles + (ext_seen ? BR_EXTRA : CYC_ZERO)))
      else $error("instruction ran a wrong number of clocks");

   br_taken_a: assert property (
      @(posedge clk) disable iff (!resetn)
      (advance && br_taken) |=> ext_st && !instr_done && exec_busy)
      else $error("taken branch did not extend");

   br_not_taken_a: assert property (
      @(posedge clk) disable iff (!resetn)
      (advance && exec_st && rem_last && cond_q && !cond_taken) |=>
         instr_done && !exec_busy)
      else $error("untaken branch did not finish on time");

   ind_two_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_ind ##1 clk_en |=> instr_done)
      else $error("indirect single byte opcode not two clocks");

   two_byte_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_two ##1 (clk_en && op_valid) |=> instr_done)
      else $error("two byte opcode not two clocks");

   three_byte_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_three ##1 (clk_en && op_valid && !instr_done)[*2] |=> instr_done)
      else $error("three byte opcode not three clocks");

   xdata_mem_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_mem ##1 (clk_en && !instr_done)[*2] |=> instr_done)
      else $error("memory move opcode not three clocks");

   // longer fixed counts: multiply four clocks, divide eight
   mul_four_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_mul ##1 (clk_en && !instr_done)[*3] |=> instr_done)
      else $error("multiply opcode not four clocks");

   div_eight_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_div ##1 (clk_en && !instr_done)[*7] |=> instr_done)
      else $error("divide opcode not eight clocks");

   // single byte opcodes owe no operand, so their ram or memory cycles refuse bytes
   ind_refuse_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_ind |=> !op_ready && exec_busy)
      else $error("indirect opcode accepted a byte in its ram cycle");

   mem_refuse_a: assert property (
      @(posedge clk) disable iff (!resetn)
      s_take_mem |=> !op_ready && exec_busy)
      else $error("memory move opcode accepted a byte in its access cycle");

   // the extension of a taken branch owes no byte and keeps execute busy
   ext_refuse_a: assert property (
      @(posedge clk) disable iff (!resetn)
      ext_st |-> !op_ready && exec_busy)
      else $error("branch extension accepted a byte or dropped busy");

   // completion frees the fetch side at once, no stall before the next opcode
   done_ready_a: assert property (
      @(posedge clk) disable iff (!resetn)
      instr_done |-> op_ready && !exec_busy)
      else $error("finished instruction left fetch refused");

   // a disabled clock counts nothing, so no cycle is counted twice or lost
   freeze_hold_a: assert property (
      @(posedge clk) disable iff (!resetn)
      !clk_en |=> $stable(state) && $stable(rem) && $stable(instr_done))
      else $error("state moved while the clock enable was low");

endmodule

/* tb/ilct_fetch_model.sv */
// program fetch model: feeds queued bytes to the timing block
`timescale 1ns/100ps
module ilct_fetch_model
   import ilct_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // handshake from the block
   input wire logic op_ready,
   // pacing control, high inserts one idle cycle after each byte taken
   input wire logic slow,
   // byte stream to the block
   output logic op_valid,
   output logic [OP_W-1:0] op_byte
);
   logic [OP_W-1:0] q[$]; // bytes still to send
   wire logic took = op_valid && op_ready && clk_en; // byte handed over at this edge

   // queue a byte for sending
   task automatic push(input logic [OP_W-1:0] b);
      q.push_back(b);
   endtask

   // hold each byte until taken, idle data toggles so a stale byte never looks valid
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         op_valid <= 1'b0;
         op_byte <= 8'h00;
      end else begin
         if (took) begin
            void'(q.pop_front());
         end
         if (took || !op_valid) begin
            if (q.size() > 0 && !(slow && took)) begin
               op_valid <= 1'b1;
               op_byte <= q[0];
            end else begin
               op_valid <= 1'b0;
               op_byte <= ~op_byte;
            end
         end
      end
   end
endmodule

/* tb/instruction_length_and_cycle_timer_tb_top.sv */
// self-checking bench for the instruction length and cycle timer
`timescale 1ns/100ps
module instruction_length_and_cycle_timer_tb_top
   import ilct_pkg::*;
;
   localparam int BR = 2; // extra cycles of a taken branch in this bench
   logic clk; // system clock, started by the clock block
   logic resetn; // stimulus starts at time zero in the main sequence
   logic clk_en;
   logic cond_taken;
   logic slow;
   logic op_valid, op_ready, dec_valid, exec_busy, instr_done;
   logic [OP_W-1:0] op_byte;
   logic [LEN_W-1:0] instr_len;
   logic [CYC_W-1:0] instr_cycles;
   int fails = 0;
   int checks = 0;
   int cyc_cnt = 0; // rising edges seen

   // design and fetch partner
   ilct_timer #(.BR_EXTRA(4'h2)) u_dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
      .op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready), .cond_taken(cond_taken),
      .dec_valid(dec_valid), .instr_len(instr_len), .instr_cycles(instr_cycles),
      .exec_busy(exec_busy), .instr_done(instr_done));
   ilct_fetch_model u_fetch (.clk(clk), .resetn(resetn), .clk_en(clk_en), .op_ready(op_ready),
      .slow(slow), .op_valid(op_valid), .op_byte(op_byte));

   // clock and edge counter
   initial clk = 1'b0;
   always #20 clk = ~clk;
   always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

   // one comparison, four-state exact
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // bounded wait for dec_valid or instr_done, returns the edge count
   task automatic wait_for(input logic sel_dec, output int k);
      int n;
      n = 0;
      if (sel_dec) begin
         @(negedge clk);
      end
      while ((sel_dec ? dec_valid : instr_done) !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (n >= 60) begin
         chk(8'h00, 8'h01);
      end
      k = cyc_cnt;
   endtask

   // send one instruction and judge length, cycles and duration
   task automatic run_op(input logic [7:0] op, input int len, input int cyc, input logic tk);
      int k0;
      int k1;
      int i;
      u_fetch.push(op);
      for (i = 1; i < len; i++) begin
         u_fetch.push(8'hA5);
      end
      @(posedge clk);
      cond_taken <= tk;
      wait_for(1'b1, k0);
      chk(8'(instr_len), 8'(len));
      chk(8'(instr_cycles), 8'(cyc));
      chk(8'(exec_busy), 8'(cyc > 1 || tk));
      chk(8'(op_ready), 8'(len > 1 || cyc == 1));
      wait_for(1'b0, k1);
      chk(8'(k1 - k0 + 1), 8'(cyc + (tk ? BR : 0) + (slow ? len - 1 : 0)));
   endtask

   // accumulator arithmetic and logic forms
   task automatic t_alu();
      run_op(8'h28, 1, 1, 0);
      run_op(8'h38, 1, 1, 0);
      run_op(8'h98, 1, 1, 0);
      run_op(8'h26, 1, 2, 0);
      run_op(8'h57, 1, 2, 0);
      run_op(8'h25, 2, 2, 0);
      run_op(8'h45, 2, 2, 0);
      run_op(8'h24, 2, 2, 0);
      run_op(8'h64, 2, 2, 0);
      run_op(8'h52, 2, 2, 0);
      run_op(8'h62, 2, 2, 0);
      run_op(8'h43, 3, 3, 0);
      run_op(8'h63, 3, 3, 0);
      run_op(8'hA4, 1, 4, 0);
      run_op(8'h84, 1, 8, 0);
      run_op(8'hA3, 1, 1, 0);
   endtask

   // all four rotates
   task automatic t_rot();
      run_op(8'h23, 1, 1, 0);
      run_op(8'h33, 1, 1, 0);
      run_op(8'h03, 1, 1, 0);
      run_op(8'h13, 1, 1, 0);
   endtask

   // data moves, code reads and external data
   task automatic t_move();
      run_op(8'h85, 3, 3, 0);
      run_op(8'hF7, 1, 2, 0);
      run_op(8'h76, 2, 2, 0);
      run_op(8'h90, 3, 3, 0);
      run_op(8'h93, 1, 3, 0);
      run_op(8'h83, 1, 3, 0);
      run_op(8'hE2, 1, 3, 0);
      run_op(8'hE0, 1, 3, 0);
      run_op(8'hF3, 1, 3, 0);
      run_op(8'hF0, 1, 3, 0);
   endtask

   // stack and exchange forms
   task automatic t_stack();
      run_op(8'hC0, 2, 2, 0);
      run_op(8'hD0, 2, 2, 0);
      run_op(8'hC5, 2, 2, 0);
      run_op(8'hD6, 1, 2, 0);
   endtask

   // conditional branches, both outcomes, two taken ones back to back
   task automatic t_branch();
      run_op(8'h60, 2, 2, 0);
      run_op(8'h60, 2, 2, 1);
      run_op(8'h40, 2, 2, 1);
      run_op(8'h50, 2, 2, 0);
      run_op(8'hB4, 3, 3, 1);
      run_op(8'hD8, 2, 2, 0);
   endtask

   // one-cycle opcodes every clock, results ready at decode
   task automatic t_b2b();
      int k;
      int i;
      u_fetch.push(8'h28);
      u_fetch.push(8'h23);
      u_fetch.push(8'h04);
      u_fetch.push(8'h38);
      wait_for(1'b1, k);
      for (i = 0; i < 3; i++) begin
         @(negedge clk);
         chk(8'(dec_valid), 8'h01);
         chk(8'(instr_done), 8'h01);
         chk(8'(instr_cycles), 8'h01);
      end
   endtask

   // clock enable low freezes the count mid-instruction
   task automatic t_freeze();
      int k0;
      int k1;
      u_fetch.push(8'hE0);
      wait_for(1'b1, k0);
      @(posedge clk);
      clk_en <= 1'b0;
      repeat (4) begin
         @(negedge clk);
         chk(8'(instr_done), 8'h00);
         chk(8'(exec_busy), 8'h01);
      end
      @(posedge clk);
      clk_en <= 1'b1;
      wait_for(1'b0, k1);
      chk(8'(k1 - k0 + 1), 8'h07);
   endtask

   // fetch gaps before operand bytes stretch only the operand cycles
   task automatic t_slow();
      @(posedge clk);
      slow <= 1'b1;
      run_op(8'h85, 3, 3, 0);
      run_op(8'h53, 3, 3, 0);
      @(posedge clk);
      slow <= 1'b0;
   endtask

   // verdict, the single exit of the run
   task automatic report_and_stop();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      report_and_stop();
   end

   // main sequence: reset values, then every scenario
   initial begin
      resetn <= 1'b0;
      clk_en <= 1'b1;
      cond_taken <= 1'b0;
      slow <= 1'b0;
      repeat (8) @(negedge clk);
      chk(8'(op_ready), 8'h01);
      chk(8'(dec_valid), 8'h00);
      chk({exec_busy, instr_done, instr_len, instr_cycles}, 8'h00);
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk({op_ready, dec_valid, exec_busy, instr_done}, 8'h08);
      t_alu();
      t_rot();
      t_move();
      t_stack();
      t_branch();
      t_b2b();
      t_freeze();
      t_slow();
      report_and_stop();
   end
endmodule
